// ### rtl/scg_defines.svh
// Purpose: named offsets, field positions and reset values of the clock gate block
// Assumes: 32-bit APB data, byte addresses
// Notes: included by the top module only; the package does not include it
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

`define SCG_BASE_ADDR 32'h400f_e000
`define SCG_BASE_MASK 32'hffff_f000
`define SCG_OFFS_MASK 32'h0000_0fff
`define SCG_OFFS_RUN_CFG 32'h0000_0200
`define SCG_OFFS_RUN_GATES 32'h0000_0104
`define SCG_OFFS_SLEEP_GATES 32'h0000_0114
`define SCG_OFFS_DEEP_GATES 32'h0000_0124

`define SCG_BIT_CMP2 26
`define SCG_BIT_CMP1 25
`define SCG_BIT_CMP0 24
`define SCG_BIT_TMR2 18
`define SCG_BIT_TMR1 17
`define SCG_BIT_TMR0 16
`define SCG_BIT_TWI0 12
`define SCG_BIT_SSP0 4
`define SCG_BIT_SER1 1
`define SCG_BIT_SER0 0
`define SCG_BIT_AUTO 0

`define SCG_GATE_MASK 32'h0707_1013
`define SCG_CFG_MASK 32'h0000_0001
`define SCG_WORD_ZERO 32'h0000_0000
`define SCG_WORD_ONES 32'hffff_ffff
`define SCG_GATES_ZERO 10'h000

`endif

// ### rtl/scg_pkg.sv
// Purpose: types shared by the clock gate block and its bench
// Assumes: constants come from scg_defines.svh
// Notes: one bit per gated peripheral unit
package scg_pkg;

   typedef struct packed {
      logic comparator_two_gate;
      logic comparator_one_gate;
      logic comparator_zero_gate;
      logic gp_counter_two_gate;
      logic gp_counter_one_gate;
      logic gp_counter_zero_gate;
      logic twowire_unit_zero_gate;
      logic sync_serial_zero_gate;
      logic serial_port_one_gate;
      logic serial_port_zero_gate;
   } scg_unit_gates_t;

   typedef struct packed {
      logic valid;
      scg_unit_gates_t sel;
   } scg_unit_access_t;

   typedef enum logic [1:0] {
      SCG_MODE_RUN = 2'h0,
      SCG_MODE_SLEEP = 2'h1,
      SCG_MODE_DEEP = 2'h2
   } scg_power_mode_t;

endpackage : scg_pkg

// ### rtl/scg_clock_gate_ctrl.sv
// Purpose: run, sleep and deep-sleep clock gate registers with APB access
// Assumes: power mode and unit access strobes come from logic on pclk
// Notes: one wait-free access phase; unit enables lag register changes by one cycle
//Contract
//- each set gate bit clocks its unit; a clear bit stops it
//- access to a unit whose clock is off returns a bus fault
//- reset clears every gate bit, leaving all units unclocked
//- separate gate registers apply in run, sleep and deep-sleep
//- sleep and deep-sleep gates apply only with automatic gating selected
//- unused bit positions are read-only and read as zero
//- sleep gate register sits at offset 0x114 from base 0x400fe000
`include "scg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module scg_clock_gate_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire scg_pkg::scg_power_mode_t power_mode,
   input wire scg_pkg::scg_unit_access_t unit_access,
   output scg_pkg::scg_unit_gates_t unit_clock_enable,
   output logic unit_bus_fault
);

   function automatic scg_pkg::scg_unit_gates_t to_gates(input logic [31:0] w);
      scg_pkg::scg_unit_gates_t g;
      g.comparator_two_gate = w[`SCG_BIT_CMP2];
      g.comparator_one_gate = w[`SCG_BIT_CMP1];
      g.comparator_zero_gate = w[`SCG_BIT_CMP0];
      g.gp_counter_two_gate = w[`SCG_BIT_TMR2];
      g.gp_counter_one_gate = w[`SCG_BIT_TMR1];
      g.gp_counter_zero_gate = w[`SCG_BIT_TMR0];
      g.twowire_unit_zero_gate = w[`SCG_BIT_TWI0];
      g.sync_serial_zero_gate = w[`SCG_BIT_SSP0];
      g.serial_port_one_gate = w[`SCG_BIT_SER1];
      g.serial_port_zero_gate = w[`SCG_BIT_SER0];
      return g;
   endfunction : to_gates

   function automatic logic [31:0] to_word(input scg_pkg::scg_unit_gates_t g);
      logic [31:0] w;
      w = `SCG_WORD_ZERO;
      w[`SCG_BIT_CMP2] = g.comparator_two_gate;
      w[`SCG_BIT_CMP1] = g.comparator_one_gate;
      w[`SCG_BIT_CMP0] = g.comparator_zero_gate;
      w[`SCG_BIT_TMR2] = g.gp_counter_two_gate;
      w[`SCG_BIT_TMR1] = g.gp_counter_one_gate;
      w[`SCG_BIT_TMR0] = g.gp_counter_zero_gate;
      w[`SCG_BIT_TWI0] = g.twowire_unit_zero_gate;
      w[`SCG_BIT_SSP0] = g.sync_serial_zero_gate;
      w[`SCG_BIT_SER1] = g.serial_port_one_gate;
      w[`SCG_BIT_SER0] = g.serial_port_zero_gate;
      return w;
   endfunction : to_word

   scg_pkg::scg_unit_gates_t run_peripheral_clock_gates_reg;
   scg_pkg::scg_unit_gates_t sleep_peripheral_clock_gates_reg;
   scg_pkg::scg_unit_gates_t deepsleep_peripheral_clock_gates_reg;
   logic auto_gating_select_reg;
   scg_pkg::scg_unit_gates_t unit_clock_enable_reg;
   scg_pkg::scg_unit_gates_t unit_clock_enable_next;
   logic unit_bus_fault_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;

   // address decode
   wire logic base_hit = (paddr & `SCG_BASE_MASK) == `SCG_BASE_ADDR;
   wire logic [31:0] offs = paddr & `SCG_OFFS_MASK;
   wire logic sel_cfg = base_hit && (offs == `SCG_OFFS_RUN_CFG);
   wire logic sel_run = base_hit && (offs == `SCG_OFFS_RUN_GATES);
   wire logic sel_sleep = base_hit && (offs == `SCG_OFFS_SLEEP_GATES);
   wire logic sel_deep = base_hit && (offs == `SCG_OFFS_DEEP_GATES);
   wire logic sel_any = sel_cfg || sel_run || sel_sleep || sel_deep;
   wire logic setup_phase = psel && !penable;
   // write commits only at the edge that completes the access phase
   wire logic wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;
   // reserved positions never store, so they read as zero
   wire scg_pkg::scg_unit_gates_t wr_gates = to_gates(pwdata & `SCG_GATE_MASK);
   wire logic [31:0] cfg_word = {31'h0000_0000, auto_gating_select_reg};
   wire logic [31:0] rd_word = sel_cfg ? cfg_word :
                               sel_run ? to_word(run_peripheral_clock_gates_reg) :
                               sel_sleep ? to_word(sleep_peripheral_clock_gates_reg) :
                               sel_deep ? to_word(deepsleep_peripheral_clock_gates_reg) :
                               `SCG_WORD_ZERO;

   // mode selection; without automatic gating run gates hold in every mode
   wire logic use_sleep = auto_gating_select_reg && (power_mode == scg_pkg::SCG_MODE_SLEEP);
   wire logic use_deep = auto_gating_select_reg && (power_mode == scg_pkg::SCG_MODE_DEEP);
   assign unit_clock_enable_next = use_sleep ? sleep_peripheral_clock_gates_reg :
                                   use_deep ? deepsleep_peripheral_clock_gates_reg :
                                   run_peripheral_clock_gates_reg;

   // gated units: checked against the enables the units really see
   wire logic access_blocked = unit_access.valid &&
                               ((unit_access.sel & ~unit_clock_enable_reg) != `SCG_GATES_ZERO);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_peripheral_clock_gates_reg <= `SCG_GATES_ZERO;
         sleep_peripheral_clock_gates_reg <= `SCG_GATES_ZERO;
         deepsleep_peripheral_clock_gates_reg <= `SCG_GATES_ZERO;
         auto_gating_select_reg <= 1'b0;
      end else if (wr_en) begin
         if (sel_cfg) begin
            auto_gating_select_reg <= pwdata[`SCG_BIT_AUTO];
         end
         if (sel_run) begin
            run_peripheral_clock_gates_reg <= wr_gates;
         end
         if (sel_sleep) begin
            sleep_peripheral_clock_gates_reg <= wr_gates;
         end
         if (sel_deep) begin
            deepsleep_peripheral_clock_gates_reg <= wr_gates;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_clock_enable_reg <= `SCG_GATES_ZERO;
         unit_bus_fault_reg <= 1'b0;
      end else begin
         unit_clock_enable_reg <= unit_clock_enable_next;
         unit_bus_fault_reg <= access_blocked;
      end
   end

   // answer is prepared in setup so every bus output comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= `SCG_WORD_ZERO;
      end else if (setup_phase) begin
         pready_reg <= 1'b1;
         pslverr_reg <= !sel_any;
         prdata_reg <= pwrite ? `SCG_WORD_ZERO : rd_word;
      end else begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= `SCG_WORD_ZERO;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign unit_clock_enable = unit_clock_enable_reg;
   assign unit_bus_fault = unit_bus_fault_reg;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup_at(logic hit);
      psel && !penable && hit;
   endsequence

   sequence s_access_done;
      psel && penable && pready;
   endsequence

   sequence s_write_to(logic hit);
      psel && penable && pready && pwrite && hit;
   endsequence

   a_reset_all_gated: assert property (disable iff (1'b0)
      !presetn |-> (unit_clock_enable == `SCG_GATES_ZERO) &&
                   (sleep_peripheral_clock_gates_reg == `SCG_GATES_ZERO) &&
                   (run_peripheral_clock_gates_reg == `SCG_GATES_ZERO) &&
                   (deepsleep_peripheral_clock_gates_reg == `SCG_GATES_ZERO))
      else $error("gate state not cleared in reset");

   a_run_write_applies: assert property (
      (wr_en && sel_run && !auto_gating_select_reg) |->
         ##2 (unit_clock_enable == to_gates($past(pwdata, 2) & `SCG_GATE_MASK)))
      else $error("run gate write did not reach unit enables");

   a_gated_access_fault: assert property (
      access_blocked |=> unit_bus_fault)
      else $error("access to unclocked unit did not fault");

   a_clocked_no_fault: assert property (
      (!unit_access.valid || ((unit_access.sel & ~unit_clock_enable) == `SCG_GATES_ZERO))
         |=> !unit_bus_fault)
      else $error("fault raised for clocked unit");

   a_mode_selects_regs: assert property (
      (auto_gating_select_reg && power_mode == scg_pkg::SCG_MODE_DEEP) |=>
         (unit_clock_enable == $past(deepsleep_peripheral_clock_gates_reg)))
      else $error("deep-sleep gates not applied");

   a_sleep_needs_auto: assert property (
      (power_mode == scg_pkg::SCG_MODE_SLEEP) |=>
         (unit_clock_enable == ($past(auto_gating_select_reg) ?
            $past(sleep_peripheral_clock_gates_reg) : $past(run_peripheral_clock_gates_reg))))
      else $error("sleep gating applied without automatic gating");

   a_reserved_read_zero: assert property (
      (s_access_done and (!pwrite && (sel_run || sel_sleep || sel_deep))) |->
         ((prdata & ~`SCG_GATE_MASK) == `SCG_WORD_ZERO))
      else $error("reserved gate bits read nonzero");

   a_sleep_offset_read: assert property (
      (s_setup_at(sel_sleep) and !pwrite) |=>
         (pready && !pslverr && prdata == to_word(sleep_peripheral_clock_gates_reg)))
      else $error("sleep gate register not decoded at its offset");

   a_gate_field_layout: assert property (
      (wr_en && sel_sleep && pwdata == `SCG_WORD_ONES) |=>
         (to_word(sleep_peripheral_clock_gates_reg) == `SCG_GATE_MASK))
      else $error("gate bit positions wrong");

   a_unmapped_error: assert property (
      (s_setup_at(!sel_any)) |=> (pready && pslverr && prdata == `SCG_WORD_ZERO))
      else $error("unmapped address not refused");

   // bus answer timing: one flop stage, one cycle, then quiet
   a_ready_after_setup: assert property (
      s_setup_at(1'b1) |=> pready)
      else $error("no ready in the cycle after setup");

   a_ready_one_cycle: assert property (
      pready |=> !pready)
      else $error("ready held beyond one cycle");

   a_idle_bus_quiet: assert property (
      !pready |-> (!pslverr && prdata == `SCG_WORD_ZERO))
      else $error("bus answer outside an access cycle");

   a_write_reads_zero: assert property (
      s_setup_at(pwrite) |=> (prdata == `SCG_WORD_ZERO))
      else $error("read data driven during a write");

   // a refused write must leave every register untouched
   a_unmapped_write_kept: assert property (
      s_write_to(!sel_any) |=>
         ($stable(run_peripheral_clock_gates_reg) &&
          $stable(sleep_peripheral_clock_gates_reg) &&
          $stable(deepsleep_peripheral_clock_gates_reg) &&
          $stable(auto_gating_select_reg)))
      else $error("refused write changed a register");

   a_sleep_write_lands: assert property (
      s_write_to(sel_sleep) |=>
         (sleep_peripheral_clock_gates_reg == to_gates($past(pwdata) & `SCG_GATE_MASK)))
      else $error("sleep gate write lost");

   a_deep_write_lands: assert property (
      s_write_to(sel_deep) |=>
         (deepsleep_peripheral_clock_gates_reg == to_gates($past(pwdata) & `SCG_GATE_MASK)))
      else $error("deep-sleep gate write lost");

   a_run_write_lands: assert property (
      s_write_to(sel_run) |=>
         (run_peripheral_clock_gates_reg == to_gates($past(pwdata) & `SCG_GATE_MASK)))
      else $error("run gate write lost");

   a_cfg_write_lands: assert property (
      s_write_to(sel_cfg) |=>
         (auto_gating_select_reg == |($past(pwdata) & `SCG_CFG_MASK)))
      else $error("automatic gating select write lost");

   a_cfg_reserved_zero: assert property (
      (s_setup_at(sel_cfg) and !pwrite) |=>
         (((prdata & ~`SCG_CFG_MASK) == `SCG_WORD_ZERO) &&
          (prdata[`SCG_BIT_AUTO] == auto_gating_select_reg)))
      else $error("configuration word reads wrong");

   a_sleep_mode_gates: assert property (
      (auto_gating_select_reg && power_mode == scg_pkg::SCG_MODE_SLEEP) |=>
         (unit_clock_enable == $past(sleep_peripheral_clock_gates_reg)))
      else $error("sleep gates not applied");

   // without automatic gating, or in run mode, only the run gates count
   a_run_gates_default: assert property (
      (!auto_gating_select_reg || power_mode == scg_pkg::SCG_MODE_RUN) |=>
         (unit_clock_enable == $past(run_peripheral_clock_gates_reg)))
      else $error("run gates not applied");

   a_idle_no_fault: assert property (
      !unit_access.valid |=> !unit_bus_fault)
      else $error("fault raised with no unit access");

   // gate and select bits move only through a decoded bus write
   wire logic sleep_write = wr_en && sel_sleep;
   wire logic cfg_write = wr_en && sel_cfg;

   a_sleep_only_by_write: assert property (
      $changed(sleep_peripheral_clock_gates_reg) |-> $past(sleep_write))
      else $error("sleep gates changed without a write");

   a_cfg_only_by_write: assert property (
      $changed(auto_gating_select_reg) |-> $past(cfg_write))
      else $error("automatic gating select changed without a write");

endmodule : scg_clock_gate_ctrl

`default_nettype wire

// ### test/sleep_clock_gate_control_tb.sv
// Purpose: self-checking bench for the sleep clock gate control block
// Assumes: zero-wait APB slave; unit enables follow register or mode one edge later
// Notes: no partner model, the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none

module sleep_clock_gate_control_tb;
   localparam logic [31:0] BASE = 32'h400f_e000;
   localparam logic [31:0] RUN_A = BASE + 32'h0000_0104;
   localparam logic [31:0] SLP_A = BASE + 32'h0000_0114;
   localparam logic [31:0] DEEP_A = BASE + 32'h0000_0124;
   localparam logic [31:0] CFG_A = BASE + 32'h0000_0200;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   scg_pkg::scg_power_mode_t power_mode = scg_pkg::SCG_MODE_RUN;
   scg_pkg::scg_unit_access_t unit_access = '0;
   scg_pkg::scg_unit_gates_t unit_clock_enable;
   logic unit_bus_fault;
   int failures = 0;
   int n_tests = 0;
   logic [31:0] rd;
   logic err;

   always #50 pclk = ~pclk;

   scg_clock_gate_ctrl DUT (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .power_mode(power_mode),
      .unit_access(unit_access),
      .unit_clock_enable(unit_clock_enable),
      .unit_bus_fault(unit_bus_fault)
   );

   task automatic stop_test;
      if (failures == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // entered just after a rising edge; holds the request until pready is seen
   task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk(n, 32'h0000_0001);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
      apb(1'b1, addr, wd);
      chk({31'h0, err}, 32'h0000_0000);
   endtask : wr

   task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0000_0000);
      chk(rd, exp);
   endtask : rd_chk

   // enables are registered, so two edges cover register and mode changes
   task automatic en_chk(input logic [9:0] exp);
      repeat (2) @(posedge pclk);
      #1;
      chk({22'h0, unit_clock_enable}, {22'h0, exp});
      @(posedge pclk);
   endtask : en_chk

   task automatic probe(input logic [9:0] sel, input logic exp);
      unit_access <= {1'b1, sel};
      @(posedge pclk);
      unit_access <= '0;
      #1;
      chk({31'h0, unit_bus_fault}, {31'h0, exp});
      @(posedge pclk);
   endtask : probe

   task automatic t_reset;
      rd_chk(RUN_A, 32'h0000_0000);
      rd_chk(SLP_A, 32'h0000_0000);
      rd_chk(DEEP_A, 32'h0000_0000);
      rd_chk(CFG_A, 32'h0000_0000);
      en_chk(10'h000);
   endtask : t_reset

   task automatic t_layout;
      wr(SLP_A, 32'hffff_ffff);
      rd_chk(SLP_A, 32'h0707_1013);
      wr(RUN_A, 32'hf8f8_efec);
      rd_chk(RUN_A, 32'h0000_0000);
      wr(CFG_A, 32'hffff_ffff);
      rd_chk(CFG_A, 32'h0000_0001);
      apb(1'b1, SLP_A + 32'h0000_0004, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001);
      apb(1'b0, SLP_A + 32'h0000_0004, 32'h0000_0000);
      chk({err, rd[30:0]}, 32'h8000_0000);
      rd_chk(SLP_A, 32'h0707_1013);
   endtask : t_layout

   task automatic t_modes;
      wr(RUN_A, 32'h0000_0001);
      wr(DEEP_A, 32'h0100_0000);
      wr(CFG_A, 32'h0000_0000);
      power_mode <= scg_pkg::SCG_MODE_SLEEP;
      en_chk(10'h001);
      power_mode <= scg_pkg::SCG_MODE_DEEP;
      en_chk(10'h001);
      wr(CFG_A, 32'h0000_0001);
      en_chk(10'h080);
      power_mode <= scg_pkg::SCG_MODE_SLEEP;
      en_chk(10'h3ff);
      power_mode <= scg_pkg::SCG_MODE_RUN;
      en_chk(10'h001);
   endtask : t_modes

   task automatic t_fault;
      probe(10'h001, 1'b0);
      probe(10'h200, 1'b1);
      probe(10'h3ff, 1'b1);
      probe(10'h002, 1'b1);
      power_mode <= scg_pkg::SCG_MODE_SLEEP;
      en_chk(10'h3ff);
      probe(10'h200, 1'b0);
      probe(10'h3ff, 1'b0);
      wr(SLP_A, 32'h0000_0000);
      en_chk(10'h000);
      probe(10'h010, 1'b1);
   endtask : t_fault

   // reset in mid-run must clear gates that were set
   task automatic t_reset_mid;
      wr(SLP_A, 32'h0707_1013);
      en_chk(10'h3ff);
      presetn <= 1'b0;
      @(posedge pclk);
      #1;
      chk({22'h0, unit_clock_enable}, 32'h0000_0000);
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
   endtask : t_reset_mid

   // the whole run is about 125 cycles
   initial begin
      #200000;
      failures++;
      stop_test();
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_layout();
      t_modes();
      t_fault();
      t_reset_mid();
      stop_test();
   end
endmodule : sleep_clock_gate_control_tb

`default_nettype wire
